/* File: verilog/aicfg_pkg.sv */
package aicfg_pkg;

   // Word addresses on the module I/O bus.
   localparam logic [3:0] ADDR_CFG_STATUS = 4'h0;
   localparam logic [3:0] ADDR_DATA_LAST  = 4'hb;
   localparam logic [3:0] ADDR_POINT_QUAL = 4'hc;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'hd;
   localparam logic [3:0] ADDR_SECONDARY  = 4'he;
   localparam logic [3:0] ADDR_IRQ_CLEAR  = 4'hf;
   // Register outside the documented word map.
   localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h10;

   // Bit positions of the configuration / module status word.
   localparam int BIT_CONFIGURED   = 0;
   localparam int BIT_ERROR        = 1;
   localparam int BIT_WARMING      = 4;
   localparam int BIT_NOT_CAL      = 7;
   localparam int BIT_RATE_50HZ    = 8;
   localparam int BIT_RANGE_LO     = 9;
   localparam int BIT_RANGE_HI     = 10;
   localparam int BIT_SELF_CAL     = 11;
   localparam int BIT_MEM_ERROR    = 13;
   localparam int BIT_TEMP_FAIL    = 14;
   localparam int BIT_POINT_FAULT  = 15;

   // Interrupt status bits.
   localparam int IRQ_WARM_DONE   = 0;
   localparam int IRQ_ERROR_RISE  = 1;
   localparam int IRQ_POINT_FAULT = 2;
   localparam int IRQ_SELF_CAL    = 3;
   localparam int IRQ_WIDTH       = 4;

   localparam logic [15:0] ATTENTION_WORD = 16'hffff;
   localparam logic [15:0] CFG_RESET      = 16'h0000;

   // Warm-up interval after power-up, and the converter rate timing.
   localparam longint CLK_HZ          = 125000000;
   localparam longint WARM_TIME_MS    = 8160;
   localparam longint WARM_CYCLES     = (WARM_TIME_MS * CLK_HZ) / 1000;
   localparam int     SELF_CAL_RATE   = 2;
   localparam longint SELF_CAL_CYCLES = CLK_HZ / SELF_CAL_RATE;
   localparam int     RATE_60         = 60;
   localparam int     RATE_50         = 50;

   typedef enum logic [1:0] {
      RANGE_FULL,
      RANGE_MID,
      RANGE_LOW,
      RANGE_INVALID
   } range_sel_t;

endpackage

/* File: verilog/analog_input_config_status_reg.sv */
`timescale 1ns/1ns
//Contract
// - Writing bit 0 configures the module; reading bit 0 returns configured state.
// - Unconfigured module returns attention on reads of words 0 through 11.
// - Writing 1 to bit 1 forces error state and lights error indicator.
// - Read bit 1 is internal OR forced error OR warming, checksum or memory error; error indicator equals it.
// - While bit 1 is set, reads of words 0 through 11 give attention.
// - Unused status bits 2-3, 5-6, 12, and 14 high-voltage read zero.
// - Warming bit 4 set for 8.16 s after power-up; error held meanwhile.
// - Bit 7 shows calibration checksum failure; lights error, sets point fault.
// - Bit 8 selects and reads back rate: 0 is 60/s, 1 is 50/s.
// - High-voltage 14-bit range decode 10V,5V,2.5V,invalid; in 13-bit mode bits 9-10 read zero and no invalid flag is set, but range_o still follows them.
// - Low-millivolt range decode 20, 50, 100 mV, and invalid.
// - Writing bit 11 starts self-calibration at 2 samples/s; reads zero.
// - Bit 13 flags internal memory error; lights error, sets point fault.
// - Low-millivolt variant sets bit 14 on temperature sensor failure.
// - Bit 15 is OR of point quality flags and bits 1,4,7,13.
// - Point quality word 12 holds data only when fault comes from points.
// - Point n uses bit 2(n-1) for comms fail, next bit for overrange.
module analog_input_config_status_reg #(
   parameter bit     LOW_MV_VARIANT = 1'b0,
   parameter bit     MODE_14BIT     = 1'b1,
   parameter int     POINTS         = 8,
   parameter longint WARM_CYCLES    = aicfg_pkg::WARM_CYCLES,
   parameter longint CAL_CYCLES     = aicfg_pkg::SELF_CAL_CYCLES
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic [4:0]        addr_i,
   input  wire logic [15:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic              int_error_i,
   input  wire logic              cal_sum_fail_i,
   input  wire logic              mem_error_i,
   input  wire logic              temp_fail_i,
   input  wire logic [2*POINTS-1:0] point_flags_i,
   input  wire logic [15:0]       data_word_i,
   output logic [15:0]            rdata_o,
   output logic                   attention_o,
   output logic                   error_led_o,
   output logic                   rate_50hz_o,
   output logic [1:0]             range_o,
   output logic                   range_invalid_o,
   output logic                   self_cal_o,
   output logic                   sample_tick_o,
   output logic                   irq_o
);

   localparam int WARM_W = $clog2(WARM_CYCLES + 1);
   localparam int CAL_W  = $clog2(CAL_CYCLES + 1);

   logic                 configured_r;
   logic                 forced_err_r;
   logic                 rate_50hz_r;
   logic [1:0]           range_r;
   logic                 range_invalid_r;
   logic                 self_cal_r;
   logic [WARM_W-1:0]    warm_cnt_r;
   logic [CAL_W-1:0]     cal_cnt_r;
   logic [15:0]          rdata_r;
   logic                 attention_r;
   logic                 error_led_r;
   logic                 sample_tick_r;
   logic                 irq_r;
   logic [aicfg_pkg::IRQ_WIDTH-1:0] irq_stat_r;
   logic [aicfg_pkg::IRQ_WIDTH-1:0] irq_en_r;
   logic                 err_d_r;
   logic                 pf_d_r;
   logic                 warm_d_r;

   // Reduce a per-point flag vector to one fault bit.
   function automatic logic any_flag(input logic [2*POINTS-1:0] v);
      any_flag = |v;
   endfunction

   wire warming     = (warm_cnt_r != '0);
   wire err_bit     = int_error_i | forced_err_r | warming
                      | cal_sum_fail_i | mem_error_i;
   wire module_err  = err_bit | warming | cal_sum_fail_i | mem_error_i;
   wire point_bad   = any_flag(point_flags_i);
   wire point_fault = point_bad | module_err;
   wire temp_bit    = LOW_MV_VARIANT & temp_fail_i;
   wire range_used  = LOW_MV_VARIANT | MODE_14BIT;
   wire [1:0] range_rd = range_used ? range_r : 2'b00;

   // Status word; unused bits are left zero.
   wire [15:0] status_word = {point_fault, temp_bit, mem_error_i, 1'b0,
                              1'b0, range_rd[1], range_rd[0], rate_50hz_r,
                              cal_sum_fail_i, 2'b00, warming, 2'b00,
                              err_bit, configured_r};

   wire wr_cfg   = wr_i && (addr_i == {1'b0, aicfg_pkg::ADDR_CFG_STATUS});
   wire wr_clr   = wr_i && (addr_i == {1'b0, aicfg_pkg::ADDR_IRQ_CLEAR});
   wire wr_en    = wr_i && (addr_i == aicfg_pkg::ADDR_IRQ_ENABLE);
   wire data_win = (addr_i <= {1'b0, aicfg_pkg::ADDR_DATA_LAST});
   wire attn     = data_win && (!configured_r || err_bit);

   // Quality word only carries data when points, not the module, cause the fault.
   wire [15:0] qual_word = module_err ? 16'h0000 : 16'(point_flags_i);

   wire [15:0] rd_mux =
      attn ? aicfg_pkg::ATTENTION_WORD :
      (addr_i == {1'b0, aicfg_pkg::ADDR_CFG_STATUS}) ? status_word :
      data_win ? data_word_i :
      (addr_i == {1'b0, aicfg_pkg::ADDR_POINT_QUAL}) ? qual_word :
      (addr_i == {1'b0, aicfg_pkg::ADDR_IRQ_STATUS}) ? 16'(irq_stat_r) :
      (addr_i == aicfg_pkg::ADDR_IRQ_ENABLE) ? 16'(irq_en_r) :
      16'h0000;

   // Events feeding the sticky interrupt bits.
   wire [aicfg_pkg::IRQ_WIDTH-1:0] irq_evt = {
      (cal_cnt_r == CAL_W'(1)),
      (point_fault & !pf_d_r),
      (err_bit & !err_d_r),
      (warm_d_r & !warming)};
   wire [aicfg_pkg::IRQ_WIDTH-1:0] irq_clr = wr_clr ? wdata_i[aicfg_pkg::IRQ_WIDTH-1:0] : '0;
   // Set wins over clear so no event is lost in the clearing cycle.
   wire [aicfg_pkg::IRQ_WIDTH-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

   wire cal_start = wr_cfg && wdata_i[aicfg_pkg::BIT_SELF_CAL];
   wire cal_tick  = self_cal_r && (cal_cnt_r == CAL_W'(1));
   // Self-calibration runs for one slow sample period of 2 per second.
   wire [CAL_W-1:0] cal_cnt_nxt = cal_start ? CAL_W'(CAL_CYCLES) :
                                  (cal_cnt_r != '0) ? cal_cnt_r - CAL_W'(1) : '0;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         configured_r <= 1'b0;
         forced_err_r <= 1'b0;
         rate_50hz_r  <= 1'b0;
         range_r      <= 2'b00;
         range_invalid_r <= 1'b0;
      end else if (wr_cfg) begin
         // Factory diagnostic bits are expected to be written as zero and are dropped.
         configured_r <= wdata_i[aicfg_pkg::BIT_CONFIGURED];
         forced_err_r <= wdata_i[aicfg_pkg::BIT_ERROR];
         rate_50hz_r  <= wdata_i[aicfg_pkg::BIT_RATE_50HZ];
         range_r      <= {wdata_i[aicfg_pkg::BIT_RANGE_HI],
                          wdata_i[aicfg_pkg::BIT_RANGE_LO]};
         range_invalid_r <= range_used & wdata_i[aicfg_pkg::BIT_RANGE_HI]
                            & wdata_i[aicfg_pkg::BIT_RANGE_LO];
      end
   end

   // Warm-up counter starts loaded so that bit 4 is set straight out of reset.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         warm_cnt_r <= WARM_W'(WARM_CYCLES);
      end else if (warming) begin
         warm_cnt_r <= warm_cnt_r - WARM_W'(1);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cal_cnt_r     <= '0;
         self_cal_r    <= 1'b0;
         sample_tick_r <= 1'b0;
      end else begin
         cal_cnt_r     <= cal_cnt_nxt;
         self_cal_r    <= cal_start | (self_cal_r & !cal_tick);
         sample_tick_r <= cal_tick;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r     <= 16'h0000;
         attention_r <= 1'b0;
      end else begin
         rdata_r     <= rd_i ? rd_mux : 16'h0000;
         attention_r <= rd_i & attn;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat_r  <= '0;
         irq_en_r    <= '0;
         irq_r       <= 1'b0;
         // Error and fault are high out of reset, so no false rising edge follows it.
         err_d_r     <= 1'b1;
         pf_d_r      <= 1'b1;
         warm_d_r    <= 1'b0;
         error_led_r <= 1'b1;
      end else begin
         irq_stat_r  <= irq_stat_nxt;
         irq_en_r    <= wr_en ? wdata_i[aicfg_pkg::IRQ_WIDTH-1:0] : irq_en_r;
         irq_r       <= |(irq_stat_nxt & irq_en_r);
         err_d_r     <= err_bit;
         pf_d_r      <= point_fault;
         warm_d_r    <= warming;
         error_led_r <= err_bit;
      end
   end

   assign rdata_o         = rdata_r;
   assign attention_o     = attention_r;
   assign error_led_o     = error_led_r;
   assign rate_50hz_o     = rate_50hz_r;
   assign range_o         = range_r;
   assign range_invalid_o = range_invalid_r;
   assign self_cal_o      = self_cal_r;
   assign sample_tick_o   = sample_tick_r;
   assign irq_o           = irq_r;

   a_warm_holds_err: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      warming |=> error_led_o) else $error("error indicator off during warm-up");
   a_led_tracks_err: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      1'b1 |=> (error_led_o == $past(err_bit))) else $error("indicator not equal error bit");
   a_attn_unconfig: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && data_win && !configured_r) |=> (attention_o && rdata_o == 16'hffff))
      else $error("unconfigured read gave no attention");
   a_attn_on_error: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && data_win && err_bit) |=> attention_o) else $error("error read gave no attention");
   a_cfg_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_cfg && !warming && !err_bit) |=> (configured_r == $past(wdata_i[0])))
      else $error("configured bit did not follow write");
   a_force_error: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_cfg && wdata_i[1]) |=> ##1 error_led_o) else $error("forced error not shown");
   a_unused_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (status_word[3:2] == 2'b00 && status_word[6:5] == 2'b00 && !status_word[12]
       && !status_word[11] && (LOW_MV_VARIANT || !status_word[14])) )
      else $error("unused status bit set");
   a_fault_or: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (mem_error_i || cal_sum_fail_i) |-> status_word[15]) else $error("point fault missing");
   a_qual_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && addr_i == 5'h0c && module_err && configured_r) |=> rdata_o == 16'h0000)
      else $error("quality word nonzero on module fault");
   a_rate_rb: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_cfg |=> rate_50hz_o == $past(wdata_i[8])) else $error("rate not taken");

   // Further checks on status decoding, self-calibration and the interrupt bits.
   a_warm_bit_set: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      warming |-> status_word[4])
      else $error("warming bit not shown");

   a_warm_ends: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (warming && warm_cnt_r == WARM_W'(1)) |=> !warming)
      else $error("warm-up did not end");

   a_warm_no_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !warming |=> !warming)
      else $error("warm-up restarted");

   a_err_has_forced: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      forced_err_r |-> err_bit)
      else $error("forced error missing from error bit");

   a_err_has_int: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      int_error_i |-> err_bit)
      else $error("internal error missing from error bit");

   a_status_err_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      status_word[1] == err_bit)
      else $error("status bit 1 differs from error");

   a_cal_fail_led: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cal_sum_fail_i |=> error_led_o)
      else $error("checksum failure left indicator off");

   a_cal_fail_pf: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cal_sum_fail_i |-> status_word[15])
      else $error("checksum failure left point fault clear");

   a_cal_bit7: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      status_word[7] == cal_sum_fail_i)
      else $error("status bit 7 wrong");

   a_mem_led: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      mem_error_i |=> error_led_o)
      else $error("memory error left indicator off");

   a_mem_bit13: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      status_word[13] == mem_error_i)
      else $error("status bit 13 wrong");

   a_temp_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      status_word[14] == (LOW_MV_VARIANT && temp_fail_i))
      else $error("status bit 14 wrong for variant");

   a_fault_points: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (|point_flags_i) |-> status_word[15])
      else $error("bad point not in point fault");

   a_fault_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (!point_bad && !err_bit && !warming && !cal_sum_fail_i && !mem_error_i)
      |-> !status_word[15])
      else $error("point fault set with no cause");

   a_fault_warm: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      warming |-> status_word[15])
      else $error("warm-up not in point fault");

   a_rate_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !wr_cfg |=> $stable(rate_50hz_o))
      else $error("rate changed without write");

   a_range_take: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_cfg |=> range_o == $past(wdata_i[10:9]))
      else $error("range not taken");

   a_range_invalid: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      range_invalid_o == (range_o == 2'b11 && range_used))
      else $error("invalid range flag wrong");

   a_range_13bit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !range_used |-> status_word[10:9] == 2'b00)
      else $error("range bits shown in 13-bit mode");

   a_selfcal_start: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cal_start |=> self_cal_o)
      else $error("self-calibration did not start");

   a_selfcal_end: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (self_cal_o && cal_cnt_r == CAL_W'(1) && !cal_start) |=> (!self_cal_o && sample_tick_o))
      else $error("self-calibration did not end");

   a_selfcal_len: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      self_cal_o |-> cal_cnt_r != '0)
      else $error("self-calibration without count");

   a_tick_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      sample_tick_o |=> !sample_tick_o)
      else $error("sample tick longer than one cycle");

   a_attn_window: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && !data_win) |=> !attention_o)
      else $error("attention outside data words");

   a_attn_word: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      attention_o |-> rdata_o == aicfg_pkg::ATTENTION_WORD)
      else $error("attention without attention word");

   a_read_stands: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !rd_i |=> (!attention_o && rdata_o == 16'h0000))
      else $error("read data stood too long");

   a_cfg_bit0: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      status_word[0] == configured_r)
      else $error("status bit 0 wrong");

   a_cfg_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !wr_cfg |=> $stable(configured_r))
      else $error("configured changed without write");

   a_forced_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_cfg && !wdata_i[1]) |=> !forced_err_r)
      else $error("forced error not released");

   a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && addr_i == 5'h00 && !attn) |=> rdata_o == $past(status_word))
      else $error("status read wrong");

   a_qual_points: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_i && addr_i == {1'b0, aicfg_pkg::ADDR_POINT_QUAL} && !module_err)
      |=> rdata_o == 16'($past(point_flags_i)))
      else $error("quality word wrong");

   a_irq_level: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      irq_o == |(irq_stat_r & $past(irq_en_r)))
      else $error("interrupt level wrong");

   a_irq_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (irq_stat_r[0] && !wr_clr) |=> irq_stat_r[0])
      else $error("sticky bit lost");

   a_irq_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (irq_evt[1] && wr_clr) |=> irq_stat_r[1])
      else $error("event lost to clear");

   a_warm_evt: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (warm_d_r && !warming) |=> irq_stat_r[0])
      else $error("warm-up end not flagged");

endmodule // analog_input_config_status_reg

/* File: verification/ctrl_bus_model.sv */
`timescale 1ns/1ns
module ctrl_bus_model (
   input  wire logic        sys_clk_i,
   input  wire logic [15:0] rdata_i,
   input  wire logic        attention_i,
   output logic [4:0]       addr_o,
   output logic [15:0]      wdata_o,
   output logic             wr_o,
   output logic             rd_o
);
   logic [15:0] rd_val;
   logic        rd_att;
   initial begin
      addr_o  = 5'h00;
      wdata_o = 16'h0000;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // Factory-only configuration bits are always sent as zero.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      addr_o  <= a;
      wdata_o <= (a == 5'h00) ? (d & 16'h8f03) : d;
      wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      wr_o    <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [4:0] a);
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      rd_o   <= 1'b0;
      #1;
      rd_val = rdata_i;
      rd_att = attention_i;
   endtask
endmodule // ctrl_bus_model

/* File: verification/analog_input_config_status_reg_tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module analog_input_config_status_reg_tb_top;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, data_word = 16'h1234, point_flags = 16'h0000;
   logic        wr, rd, attention, error_led, rate_50hz, range_invalid;
   logic        int_error = 1'b0, cal_sum_fail = 1'b0, mem_error = 1'b0;
   logic        temp_fail = 1'b1, self_cal, sample_tick, irq;
   logic [1:0]  range;
   int          err_total = 0;
   int          check_count = 0;
   always #4 sys_clk = ~sys_clk;
   // Short warm-up and calibration counts keep the run brief.
   analog_input_config_status_reg #(.WARM_CYCLES(50), .CAL_CYCLES(20))
      i_analog_input_config_status_reg (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .int_error_i(int_error),
      .cal_sum_fail_i(cal_sum_fail), .mem_error_i(mem_error), .temp_fail_i(temp_fail),
      .point_flags_i(point_flags), .data_word_i(data_word), .rdata_o(rdata),
      .attention_o(attention), .error_led_o(error_led), .rate_50hz_o(rate_50hz),
      .range_o(range), .range_invalid_o(range_invalid), .self_cal_o(self_cal),
      .sample_tick_o(sample_tick), .irq_o(irq));
   logic [15:0] lmv_rdata;
   // A second instance covers the low-millivolt decoding of bits 9, 10 and 14.
   analog_input_config_status_reg #(.LOW_MV_VARIANT(1'b1), .WARM_CYCLES(50), .CAL_CYCLES(20))
      i_analog_input_config_status_reg_lmv (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .int_error_i(int_error),
      .cal_sum_fail_i(cal_sum_fail), .mem_error_i(mem_error), .temp_fail_i(temp_fail),
      .point_flags_i(point_flags), .data_word_i(data_word), .rdata_o(lmv_rdata),
      .attention_o(), .error_led_o(), .rate_50hz_o(), .range_o(), .range_invalid_o(),
      .self_cal_o(), .sample_tick_o(), .irq_o());
   ctrl_bus_model i_ctrl_bus_model (.sys_clk_i(sys_clk), .rdata_i(rdata),
      .attention_i(attention), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input logic att);
      i_ctrl_bus_model.rd(a);
      `CHK(i_ctrl_bus_model.rd_val, e)
      `CHK(i_ctrl_bus_model.rd_att, att)
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic warm_up_check;
      `CHK(error_led, 1'b1)
      rd_chk(5'h00, 16'hffff, 1'b1);
      rd_chk(5'h0b, 16'hffff, 1'b1);
      rd_chk(5'h0c, 16'h0000, 1'b0);
      wait_cyc(60);
      `CHK(error_led, 1'b0)
      rd_chk(5'h00, 16'hffff, 1'b1);
      i_ctrl_bus_model.wr(5'h0f, 16'h000f);
      rd_chk(5'h0d, 16'h0000, 1'b0);
   endtask
   task automatic config_modes;
      logic [15:0] cfg;
      for (int r = 0; r < 8; r++) begin
         cfg = 16'h0001;
         cfg[8] = r[2];
         cfg[9] = r[0];
         cfg[10] = r[1];
         i_ctrl_bus_model.wr(5'h00, cfg);
         rd_chk(5'h00, cfg, 1'b0);
         `CHK(lmv_rdata, cfg | 16'h4000)
         `CHK(rate_50hz, cfg[8])
         `CHK(range, {cfg[10], cfg[9]})
         `CHK(range_invalid, cfg[10] & cfg[9])
      end
   endtask
   task automatic point_faults;
      i_ctrl_bus_model.wr(5'h00, 16'h0001);
      rd_chk(5'h05, 16'h1234, 1'b0);
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         point_flags <= 16'h0001 << i;
         rd_chk(5'h00, 16'h8001, 1'b0);
         rd_chk(5'h0c, 16'h0001 << i, 1'b0);
      end
   endtask
   task automatic error_paths;
      i_ctrl_bus_model.wr(5'h10, 16'h0002);
      i_ctrl_bus_model.wr(5'h00, 16'h0003);
      wait_cyc(2);
      `CHK(error_led, 1'b1)
      `CHK(irq, 1'b1)
      rd_chk(5'h00, 16'hffff, 1'b1);
      rd_chk(5'h0c, 16'h0000, 1'b0);
      rd_chk(5'h0d, 16'h0006, 1'b0);
      i_ctrl_bus_model.wr(5'h00, 16'h0001);
      i_ctrl_bus_model.wr(5'h0f, 16'h000f);
      i_ctrl_bus_model.wr(5'h10, 16'h0000);
      wait_cyc(2);
      `CHK(irq, 1'b0)
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         {mem_error, cal_sum_fail, int_error} <= 3'b001 << k;
         point_flags <= 16'h0000;
         wait_cyc(2);
         `CHK(error_led, 1'b1)
         rd_chk(5'h00, 16'hffff, 1'b1);
         `CHK(irq, 1'b0)
         @(posedge sys_clk);
         {mem_error, cal_sum_fail, int_error} <= 3'b000;
      end
      wait_cyc(2);
      `CHK(error_led, 1'b0)
      rd_chk(5'h0d, 16'h0006, 1'b0);
      rd_chk(5'h0e, 16'h0000, 1'b0);
      rd_chk(5'h11, 16'h0000, 1'b0);
      i_ctrl_bus_model.wr(5'h0f, 16'h000f);
   endtask
   task automatic self_cal_run;
      int n;
      n = 0;
      i_ctrl_bus_model.wr(5'h00, 16'h0801);
      wait_cyc(2);
      `CHK(self_cal, 1'b1)
      while (sample_tick !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      `CHK(sample_tick, 1'b1)
      `CHK(n >= 15, 1'b1)
      rd_chk(5'h00, 16'h0001, 1'b0);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      wait_cyc(1);
      warm_up_check();
      config_modes();
      point_faults();
      error_paths();
      self_cal_run();
      summarize();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      summarize();
   end
endmodule // analog_input_config_status_reg_tb_top
